/* tmcc_pkg.sv */
// package: constants and types for the channel mode control block
package tmcc_pkg;
  localparam logic [7:0]  OFF_STAT    = 8'h04;
  localparam logic [7:0]  OFF_MODE12  = 8'h18;
  localparam logic [7:0]  OFF_MODE34  = 8'h1c;
  localparam logic [7:0]  OFF_CMP1    = 8'h34;
  localparam logic [7:0]  CHAN_RST    = 8'h00;
  localparam logic [15:0] CMP_RST     = 16'h0000;
  localparam logic [1:0]  LOCK_FULL   = 2'h3;
  localparam logic [1:0]  SEL_OUT     = 2'h0;
  localparam logic [1:0]  SEL_OWN     = 2'h1;
  localparam logic [1:0]  SEL_PAIR    = 2'h2;
  localparam logic [1:0]  SEL_TRG     = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          FAST_CYC    = 3;
  localparam int          CMP_W       = 16;

  typedef enum logic [2:0] {
    OM_FREEZE = 3'b000,
    OM_ACT    = 3'b001,
    OM_INACT  = 3'b010,
    OM_TOGGLE = 3'b011,
    OM_FLOW   = 3'b100,
    OM_FHIGH  = 3'b101,
    OM_PWM1   = 3'b110,
    OM_PWM2   = 3'b111
  } tmcc_mode_t;

  // output view of one channel byte
  typedef struct packed {
    logic       clr;
    tmcc_mode_t mode;
    logic       pre;
    logic       fast;
    logic [1:0] sel;
  } tmcc_och_t;

  // input view of one channel byte
  typedef struct packed {
    logic [3:0] filt;
    logic [1:0] psc;
    logic [1:0] sel;
  } tmcc_ich_t;

  // sample divider mask and sample count
  typedef struct packed {
    logic [4:0] mask;
    logic [3:0] n;
  } tmcc_flt_t;
endpackage : tmcc_pkg

/* tmcc_top.sv */
// channel mode control: compare reference, input filter, capture divider, bus slave
`timescale 1ns/1ps
module tmcc_top (
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  input  wire logic [7:0]               S_AXI_AWADDR,
  input  wire logic                     S_AXI_AWVALID,
  output logic                          S_AXI_AWREADY,
  input  wire logic [31:0]              S_AXI_WDATA,
  input  wire logic [3:0]               S_AXI_WSTRB,
  input  wire logic                     S_AXI_WVALID,
  output logic                          S_AXI_WREADY,
  output logic [1:0]                    S_AXI_BRESP,
  output logic                          S_AXI_BVALID,
  input  wire logic                     S_AXI_BREADY,
  input  wire logic [7:0]               S_AXI_ARADDR,
  input  wire logic                     S_AXI_ARVALID,
  output logic                          S_AXI_ARREADY,
  output logic [31:0]                   S_AXI_RDATA,
  output logic [1:0]                    S_AXI_RRESP,
  output logic                          S_AXI_RVALID,
  input  wire logic                     S_AXI_RREADY,
  input  wire logic [tmcc_pkg::CMP_W-1:0] COUNTER_VALUE,
  input  wire logic                     COUNT_DOWN,
  input  wire logic                     UPDATE_EVT,
  input  wire logic                     TRIGGER_EDGE,
  input  wire logic                     EXT_TRIGGER_FILTERED,
  input  wire logic                     INTERNAL_TRIGGER_IN,
  input  wire logic                     PIN_IN_A,
  input  wire logic                     PIN_IN_B,
  input  wire logic                     PIN_IN_C,
  input  wire logic                     PIN_IN_D,
  input  wire logic [3:0]               CHAN_ENABLE,
  input  wire logic [1:0]               LOCK_LEVEL,
  output logic [3:0]                    OUT_REFERENCE,
  output logic [3:0]                    CAPTURE_EVT
);
  localparam int CW = tmcc_pkg::CMP_W;
  localparam int TD = tmcc_pkg::FAST_CYC - 1;

  logic [7:0]    mode_reg   [4];
  logic [7:0]    mode_next  [4];
  logic [CW-1:0] shadow_reg [4];
  logic [CW-1:0] shadow_next[4];
  logic [CW-1:0] active_reg [4];
  logic [CW-1:0] active_next[4];
  logic [3:0]    fcnt_reg   [4];
  logic [3:0]    fcnt_next  [4];
  logic [2:0]    pcnt_reg   [4];
  logic [2:0]    pcnt_next  [4];
  logic [3:0]    ref_reg, ref_next, match_reg, match_next;
  logic [3:0]    flt_reg, flt_next, cap_reg, cap_next;
  logic [3:0]    sync1_reg, sync2_reg;
  logic [TD-1:0] trig_reg, trig_next;
  logic [4:0]    div_reg, div_next;
  logic          aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0]    awaddr_reg, awaddr_next;
  logic [31:0]   wdata_reg, wdata_next, rdata_reg, rdata_next, rd_word;
  logic [3:0]    wstrb_reg, wstrb_next;
  logic          bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]    bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic          wr_go, wr_hit, rd_hit;

  function automatic logic [7:0] wr_mode(input logic [7:0] old, input logic [7:0] nw,
                                         input logic en, input logic [1:0] lock);
    tmcc_pkg::tmcc_och_t o;
    tmcc_pkg::tmcc_och_t r;
    o = tmcc_pkg::tmcc_och_t'(old);
    r = tmcc_pkg::tmcc_och_t'(nw);
    if (en) begin
      r.sel = o.sel;
    end
    if (lock == tmcc_pkg::LOCK_FULL && o.sel == tmcc_pkg::SEL_OUT) begin
      r.mode = o.mode;
      r.pre  = o.pre;
    end
    return r;
  endfunction : wr_mode

  function automatic tmcc_pkg::tmcc_flt_t flt_cfg(input logic [3:0] c);
    tmcc_pkg::tmcc_flt_t f;
    f = '{5'h00, 4'h1};
    case (c)
      4'h1: f = '{5'h00, 4'h2};
      4'h2: f = '{5'h00, 4'h4};
      4'h3: f = '{5'h00, 4'h8};
      4'h4: f = '{5'h01, 4'h6};
      4'h5: f = '{5'h01, 4'h8};
      4'h6: f = '{5'h03, 4'h6};
      4'h7: f = '{5'h03, 4'h8};
      4'h8: f = '{5'h07, 4'h6};
      4'h9: f = '{5'h07, 4'h8};
      4'ha: f = '{5'h0f, 4'h5};
      4'hb: f = '{5'h0f, 4'h6};
      4'hc: f = '{5'h0f, 4'h8};
      4'hd: f = '{5'h1f, 4'h5};
      4'he: f = '{5'h1f, 4'h6};
      4'hf: f = '{5'h1f, 4'h8};
      default: f = '{5'h00, 4'h1};
    endcase
    return f;
  endfunction : flt_cfg

  assign S_AXI_AWREADY = !aw_full_reg;
  assign S_AXI_WREADY  = !w_full_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign OUT_REFERENCE = ref_reg;
  assign CAPTURE_EVT   = cap_reg;
  assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;

  // bus slave and register file
  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    mode_next    = mode_reg;
    shadow_next  = shadow_reg;
    active_next  = active_reg;
    wr_hit       = 1'b0;
    rd_hit       = 1'b1;
    rd_word      = 32'h0000_0000;
    if (S_AXI_AWVALID && !aw_full_reg) begin
      aw_full_next = 1'b1;
      awaddr_next  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_full_reg) begin
      w_full_next = 1'b1;
      wdata_next  = S_AXI_WDATA;
      wstrb_next  = S_AXI_WSTRB;
    end
    for (int i = 0; i < 4; i++) begin
      if (UPDATE_EVT && mode_reg[i][3]) begin
        active_next[i] = shadow_reg[i];
      end
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      for (int i = 0; i < 4; i++) begin
        if (awaddr_reg == (i < 2 ? tmcc_pkg::OFF_MODE12 : tmcc_pkg::OFF_MODE34)) begin
          wr_hit = 1'b1;
          if (wstrb_reg[i % 2]) begin
            mode_next[i] = wr_mode(mode_reg[i], wdata_reg[8*(i%2) +: 8],
                                   CHAN_ENABLE[i], LOCK_LEVEL);
          end
        end
        if (awaddr_reg == tmcc_pkg::OFF_CMP1 + 8'(4 * i)) begin
          wr_hit = 1'b1;
          shadow_next[i] = {wstrb_reg[1] ? wdata_reg[15:8] : shadow_reg[i][15:8],
                            wstrb_reg[0] ? wdata_reg[7:0] : shadow_reg[i][7:0]};
          if (!mode_reg[i][3]) begin
            active_next[i] = shadow_next[i];
          end
        end
      end
      bresp_next = wr_hit ? tmcc_pkg::RESP_OKAY : tmcc_pkg::RESP_SLVERR;
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    case (S_AXI_ARADDR)
      tmcc_pkg::OFF_MODE12: rd_word = {16'h0000, mode_reg[1], mode_reg[0]};
      tmcc_pkg::OFF_MODE34: rd_word = {16'h0000, mode_reg[3], mode_reg[2]};
      tmcc_pkg::OFF_STAT:   rd_word = {24'h00_0000, flt_reg, ref_reg};
      default:              rd_hit = 1'b0;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (S_AXI_ARADDR == tmcc_pkg::OFF_CMP1 + 8'(4 * i)) begin
        rd_hit  = 1'b1;
        rd_word = {16'h0000, shadow_reg[i]};
      end
    end
    if (S_AXI_ARVALID && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_word;
      rresp_next  = rd_hit ? tmcc_pkg::RESP_OKAY : tmcc_pkg::RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  // compare reference generation
  always_comb begin
    tmcc_pkg::tmcc_och_t o;
    logic eq;
    logic lt;
    logic gt;
    o          = '0;
    eq         = 1'b0;
    lt         = 1'b0;
    gt         = 1'b0;
    trig_next  = TD'({trig_reg, TRIGGER_EDGE});
    ref_next   = ref_reg;
    match_next = match_reg;
    for (int i = 0; i < 4; i++) begin
      o  = tmcc_pkg::tmcc_och_t'(mode_reg[i]);
      eq = COUNTER_VALUE == active_reg[i];
      lt = COUNTER_VALUE < active_reg[i];
      gt = COUNTER_VALUE > active_reg[i];
      match_next[i] = eq;
      case (o.mode)
        tmcc_pkg::OM_FREEZE: ref_next[i] = ref_reg[i];
        tmcc_pkg::OM_ACT:    ref_next[i] = eq ? 1'b1 : ref_reg[i];
        tmcc_pkg::OM_INACT:  ref_next[i] = eq ? 1'b0 : ref_reg[i];
        tmcc_pkg::OM_TOGGLE: ref_next[i] = ref_reg[i] ^ (eq && !match_reg[i]);
        tmcc_pkg::OM_FLOW:   ref_next[i] = 1'b0;
        tmcc_pkg::OM_FHIGH:  ref_next[i] = 1'b1;
        tmcc_pkg::OM_PWM1:   ref_next[i] = COUNT_DOWN ? !gt : lt;
        tmcc_pkg::OM_PWM2:   ref_next[i] = COUNT_DOWN ? gt : !lt;
        default:             ref_next[i] = ref_reg[i];
      endcase
      if (o.fast && o.mode[2:1] == 2'b11 && trig_reg[TD-1]) begin
        ref_next[i] = o.mode[0];
      end
      if (o.clr && EXT_TRIGGER_FILTERED) begin
        ref_next[i] = 1'b0;
      end
    end
  end

  // input selection, filter and capture divider
  always_comb begin
    tmcc_pkg::tmcc_ich_t c;
    tmcc_pkg::tmcc_flt_t f;
    logic raw;
    logic rise;
    c         = '0;
    f         = '0;
    raw       = 1'b0;
    rise      = 1'b0;
    div_next  = div_reg + 5'h01;
    flt_next  = flt_reg;
    fcnt_next = fcnt_reg;
    pcnt_next = pcnt_reg;
    cap_next  = 4'h0;
    for (int i = 0; i < 4; i++) begin
      c = tmcc_pkg::tmcc_ich_t'(mode_reg[i]);
      f = flt_cfg(c.filt);
      case (c.sel)
        tmcc_pkg::SEL_OWN:  raw = sync2_reg[i];
        tmcc_pkg::SEL_PAIR: raw = sync2_reg[i ^ 1];
        tmcc_pkg::SEL_TRG:  raw = INTERNAL_TRIGGER_IN;
        default:            raw = 1'b0;
      endcase
      if (c.filt == 4'h0) begin
        flt_next[i]  = raw;
        fcnt_next[i] = 4'h0;
      end else if ((div_reg & f.mask) == 5'h00) begin
        if (raw == flt_reg[i]) begin
          fcnt_next[i] = 4'h0;
        end else if (fcnt_reg[i] + 4'h1 >= f.n) begin
          flt_next[i]  = raw;
          fcnt_next[i] = 4'h0;
        end else begin
          fcnt_next[i] = fcnt_reg[i] + 4'h1;
        end
      end
      rise = flt_next[i] && !flt_reg[i];
      if (!CHAN_ENABLE[i]) begin
        pcnt_next[i] = 3'h0;
      end else if (c.sel != tmcc_pkg::SEL_OUT && rise) begin
        if (pcnt_reg[i] == 3'((4'h1 << c.psc) - 4'h1)) begin
          pcnt_next[i] = 3'h0;
          cap_next[i]  = 1'b1;
        end else begin
          pcnt_next[i] = pcnt_reg[i] + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    sync1_reg <= {PIN_IN_D, PIN_IN_C, PIN_IN_B, PIN_IN_A};
    sync2_reg <= sync1_reg;
    if (!RST_N) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= tmcc_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= tmcc_pkg::RESP_OKAY;
      ref_reg     <= 4'h0;
      match_reg   <= 4'h0;
      flt_reg     <= 4'h0;
      cap_reg     <= 4'h0;
      trig_reg    <= '0;
      div_reg     <= 5'h00;
      for (int i = 0; i < 4; i++) begin
        mode_reg[i]   <= tmcc_pkg::CHAN_RST;
        shadow_reg[i] <= tmcc_pkg::CMP_RST;
        active_reg[i] <= tmcc_pkg::CMP_RST;
        fcnt_reg[i]   <= 4'h0;
        pcnt_reg[i]   <= 3'h0;
      end
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      ref_reg     <= ref_next;
      match_reg   <= match_next;
      flt_reg     <= flt_next;
      cap_reg     <= cap_next;
      trig_reg    <= trig_next;
      div_reg     <= div_next;
      mode_reg    <= mode_next;
      shadow_reg  <= shadow_next;
      active_reg  <= active_next;
      fcnt_reg    <= fcnt_next;
      pcnt_reg    <= pcnt_next;
    end
  end

  // checks on channel 1
  tmcc_pkg::tmcc_och_t om0;
  assign om0 = tmcc_pkg::tmcc_och_t'(mode_reg[0]);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_lock_mode: assert property (
    wr_go && awaddr_reg == tmcc_pkg::OFF_MODE12 && LOCK_LEVEL == tmcc_pkg::LOCK_FULL
    && om0.sel == tmcc_pkg::SEL_OUT |=> mode_reg[0][6:3] == $past(mode_reg[0][6:3]))
    else $error("locked mode bits changed");
  a_pwm1_up: assert property (
    om0.mode == tmcc_pkg::OM_PWM1 && !COUNT_DOWN && COUNTER_VALUE < active_reg[0]
    && !EXT_TRIGGER_FILTERED && !trig_reg[TD-1] |=> ref_reg[0])
    else $error("pwm1 reference not active below compare");
  a_pwm2_down: assert property (
    om0.mode == tmcc_pkg::OM_PWM2 && COUNT_DOWN && COUNTER_VALUE > active_reg[0]
    && !EXT_TRIGGER_FILTERED && !trig_reg[TD-1] |=> ref_reg[0])
    else $error("pwm2 reference not active above compare");
  a_cmp_direct: assert property (
    wr_go && awaddr_reg == tmcc_pkg::OFF_CMP1 && !om0.pre && wstrb_reg[1:0] == 2'h3
    |=> active_reg[0] == $past(wdata_reg[15:0]))
    else $error("direct compare write not applied");
  a_cmp_hold: assert property (
    om0.pre && !UPDATE_EVT |=> $stable(active_reg[0]))
    else $error("active compare changed without update");
  a_cmp_load: assert property (
    om0.pre && UPDATE_EVT |=> active_reg[0] == $past(shadow_reg[0]))
    else $error("shadow not loaded on update");
  a_fast_trig: assert property (
    TRIGGER_EDGE && om0.fast && om0.mode == tmcc_pkg::OM_PWM1 && !om0.clr
    ##1 $stable(mode_reg[0])[*2] |=> !ref_reg[0])
    else $error("fast trigger not seen in three cycles");
  a_fast_freeze: assert property (
    om0.mode == tmcc_pkg::OM_FREEZE && om0.fast && !om0.clr |=> $stable(ref_reg[0]))
    else $error("fast enable acted outside pwm");
  a_sel_guard: assert property (
    wr_go && awaddr_reg == tmcc_pkg::OFF_MODE12 && CHAN_ENABLE[0]
    |=> mode_reg[0][1:0] == $past(mode_reg[0][1:0]))
    else $error("select written while enabled");
  a_psc_clear: assert property (
    !CHAN_ENABLE[0] |=> pcnt_reg[0] == 3'h0)
    else $error("capture divider not cleared");
  a_ext_clear: assert property (
    om0.clr && EXT_TRIGGER_FILTERED |=> !ref_reg[0])
    else $error("external clear ignored");
  a_rsvd_zero: assert property (
    S_AXI_ARVALID && !rvalid_reg && S_AXI_ARADDR[7:3] == 5'h03 |=> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("reserved mode bits nonzero");

  c_pwm_edge: cover property (om0.mode == tmcc_pkg::OM_PWM1 ##1 $rose(ref_reg[0]));
  c_fast_hit: cover property (om0.fast && trig_reg[TD-1]);
  c_capture:  cover property (CAPTURE_EVT[0] && mode_reg[0][3:2] == 2'h1);
  c_write:    cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule : tmcc_top

/* tmcc_core_model.sv */
// far-side model: counter core that holds, loads or steps its count
`timescale 1ns/1ps
module tmcc_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        down_in,
  input  wire logic        step,
  output logic [15:0]      count,
  output logic             down,
  output logic             update_evt
);
  logic [15:0] count_next;
  logic        update_next;
  always_comb begin
    count_next  = count;
    if (load) count_next = load_val;
    else if (step) count_next = count + 16'h0001;
    update_next = step && (count_next == 16'h0000);
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count      <= 16'h0000;
      down       <= 1'b0;
      update_evt <= 1'b0;
    end else begin
      count      <= count_next;
      down       <= down_in;
      update_evt <= update_next;
    end
  end
endmodule : tmcc_core_model

/* tb_timer_channel_mode_control.sv */
// testbench for the channel mode control block
`timescale 1ns/1ps
module tb_timer_channel_mode_control;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [7:0]  S_AXI_AWADDR = 8'h00;
  logic [7:0]  S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0]  S_AXI_WSTRB = 4'hf;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [15:0] COUNTER_VALUE, ld_val = 16'h0;
  logic        COUNT_DOWN, UPDATE_EVT, ld = 1'b0, dn = 1'b0, step = 1'b0;
  logic        TRIGGER_EDGE = 1'b0, EXT_TRIGGER_FILTERED = 1'b0, INTERNAL_TRIGGER_IN = 1'b0;
  logic        PIN_IN_A = 1'b0, PIN_IN_B = 1'b0, PIN_IN_C = 1'b0, PIN_IN_D = 1'b0;
  logic [3:0]  CHAN_ENABLE = 4'h0, OUT_REFERENCE, CAPTURE_EVT;
  logic [1:0]  LOCK_LEVEL = 2'h0;
  int          fails = 0;
  int          checks = 0;
  int          caps [4] = '{0, 0, 0, 0};

  always #10 CLK = ~CLK;
  always @(posedge CLK)
    for (int i = 0; i < 4; i++)
      if (CAPTURE_EVT[i] === 1'b1) caps[i]++;

  tmcc_top uut (.*);
  tmcc_core_model core (
    .clk        (CLK),
    .rst_n      (RST_N),
    .load       (ld),
    .load_val   (ld_val),
    .down_in    (dn),
    .step       (step),
    .count      (COUNTER_VALUE),
    .down       (COUNT_DOWN),
    .update_evt (UPDATE_EVT)
  );

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cref(input logic e);
    chk("out_reference", {31'h0, e}, {31'h0, OUT_REFERENCE[0]});
  endtask : cref

  // one write or one read; read compares data against d
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge CLK);
    S_AXI_AWADDR  <= a;
    S_AXI_ARADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_AWVALID <= we;
    S_AXI_WVALID  <= we;
    S_AXI_BREADY  <= we;
    S_AXI_ARVALID <= !we;
    S_AXI_RREADY  <= !we;
    do begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!(we ? S_AXI_BVALID : S_AXI_RVALID) && n < 50);
    S_AXI_BREADY <= 1'b0;
    S_AXI_RREADY <= 1'b0;
    chk("answer_valid", 32'h1, {31'h0, we ? S_AXI_BVALID : S_AXI_RVALID});
    chk("resp", {30'h0, er}, {30'h0, we ? S_AXI_BRESP : S_AXI_RRESP});
    if (!we) chk("rdata", d, S_AXI_RDATA);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, tmcc_pkg::RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d, tmcc_pkg::RESP_OKAY);
  endtask : rd

  task automatic cnt(input logic [15:0] v, input logic s);
    ld_val <= v;
    ld     <= !s;
    step   <= s;
    @(posedge CLK);
    ld   <= 1'b0;
    step <= 1'b0;
  endtask : cnt

  // freeze, set the count, then switch channel 1 to mode byte b
  task automatic arm(input logic [7:0] b, input logic [15:0] v, input logic d);
    wr(tmcc_pkg::OFF_MODE12, 32'h0);
    dn <= d;
    cnt(v, 1'b0);
    wr(tmcc_pkg::OFF_MODE12, {24'h0, b});
    repeat (2) @(posedge CLK);
  endtask : arm

  task automatic pulse(input int hi);
    PIN_IN_A <= 1'b1;
    repeat (hi) @(posedge CLK);
    PIN_IN_A <= 1'b0;
    repeat (14) @(posedge CLK);
  endtask : pulse

  task automatic t_regs();
    rd(tmcc_pkg::OFF_MODE12, 32'h0);
    rd(tmcc_pkg::OFF_MODE34, 32'h0);
    bus(1'b0, 8'h08, 32'h0, tmcc_pkg::RESP_SLVERR);
    bus(1'b1, 8'h08, 32'hffffffff, tmcc_pkg::RESP_SLVERR);
    wr(tmcc_pkg::OFF_MODE12, 32'hffffffff);
    rd(tmcc_pkg::OFF_MODE12, 32'h0000ffff);
    wr(tmcc_pkg::OFF_MODE34, 32'h12345678);
    rd(tmcc_pkg::OFF_MODE34, 32'h00005678);
    rd(tmcc_pkg::OFF_STAT, 32'h0000000f);
    chk("out_reference", 32'hf, {28'h0, OUT_REFERENCE});
    $display("registers done");
  endtask : t_regs

  task automatic t_pwm();
    logic [2:0] m [10] = '{3'h6, 3'h6, 3'h6, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7, 3'h5, 3'h4};
    logic [2:0] c [10] = '{3'h4, 3'h5, 3'h5, 3'h6, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h4};
    logic [9:0] d = 10'h0cc;
    logic [9:0] e = 10'h1a5;
    wr(tmcc_pkg::OFF_MODE12, 32'h0);
    wr(tmcc_pkg::OFF_CMP1, 32'h5);
    for (int i = 0; i < 10; i++) begin
      arm({1'b0, m[i], 4'h0}, {13'h0, c[i]}, d[i]);
      cref(e[i]);
    end
    arm(8'h60, 16'h4, 1'b0);
    cref(1'b1);
    wr(tmcc_pkg::OFF_CMP1, 32'h4);
    repeat (2) @(posedge CLK);
    cref(1'b0);
    arm(8'h68, 16'h3, 1'b0);
    wr(tmcc_pkg::OFF_CMP1, 32'h0);
    repeat (2) @(posedge CLK);
    cref(1'b1);
    rd(tmcc_pkg::OFF_CMP1, 32'h0);
    cnt(16'hffff, 1'b0);
    @(posedge CLK);
    cnt(16'h0, 1'b1);
    repeat (3) @(posedge CLK);
    cref(1'b0);
    $display("compare modes done");
  endtask : t_pwm

  task automatic t_lock();
    wr(tmcc_pkg::OFF_MODE12, 32'h60);
    LOCK_LEVEL <= tmcc_pkg::LOCK_FULL;
    wr(tmcc_pkg::OFF_MODE12, 32'h7c);
    rd(tmcc_pkg::OFF_MODE12, 32'h64);
    LOCK_LEVEL  <= 2'h0;
    CHAN_ENABLE <= 4'h1;
    wr(tmcc_pkg::OFF_MODE12, 32'h61);
    rd(tmcc_pkg::OFF_MODE12, 32'h60);
    CHAN_ENABLE <= 4'h0;
    $display("lock done");
  endtask : t_lock

  task automatic t_fast();
    logic [7:0] b [3] = '{8'h64, 8'h60, 8'h54};
    wr(tmcc_pkg::OFF_CMP1, 32'h5);
    for (int i = 0; i < 3; i++) begin
      arm(b[i], 16'h4, 1'b0);
      TRIGGER_EDGE <= 1'b1;
      @(posedge CLK);
      TRIGGER_EDGE <= 1'b0;
      repeat (2) @(posedge CLK);
      cref(1'b1);
      @(posedge CLK);
      cref(i != 0);
    end
    arm(8'he0, 16'h4, 1'b0);
    EXT_TRIGGER_FILTERED <= 1'b1;
    repeat (2) @(posedge CLK);
    cref(1'b0);
    arm(8'h60, 16'h4, 1'b0);
    cref(1'b1);
    EXT_TRIGGER_FILTERED <= 1'b0;
    $display("trigger and clear done");
  endtask : t_fast

  task automatic t_cap();
    int base;
    for (int p = 0; p < 4; p++) begin
      CHAN_ENABLE <= 4'h0;
      wr(tmcc_pkg::OFF_MODE12, {28'h0, 2'(p), 2'h1});
      CHAN_ENABLE <= 4'h1;
      base = caps[0];
      repeat (8) pulse(2);
      chk("captures", 32'h8 >> p, caps[0] - base);
    end
    repeat (4) pulse(2);
    CHAN_ENABLE <= 4'h0;
    @(posedge CLK);
    CHAN_ENABLE <= 4'h1;
    base = caps[0];
    repeat (4) pulse(2);
    chk("captures", 32'h0, caps[0] - base);
    CHAN_ENABLE <= 4'h0;
    wr(tmcc_pkg::OFF_MODE12, 32'h3200);
    CHAN_ENABLE <= 4'h2;
    base = caps[1];
    pulse(6);
    pulse(12);
    chk("captures", 32'h1, caps[1] - base);
    CHAN_ENABLE <= 4'h0;
    wr(tmcc_pkg::OFF_MODE12, 32'h3);
    CHAN_ENABLE <= 4'h1;
    base = caps[0];
    INTERNAL_TRIGGER_IN <= 1'b1;
    repeat (4) @(posedge CLK);
    INTERNAL_TRIGGER_IN <= 1'b0;
    repeat (2) @(posedge CLK);
    chk("captures", 32'h1, caps[0] - base);
    CHAN_ENABLE <= 4'h0;
    wr(tmcc_pkg::OFF_MODE34, 32'h0200);
    CHAN_ENABLE <= 4'h8;
    base = caps[3];
    PIN_IN_C <= 1'b1;
    repeat (8) @(posedge CLK);
    PIN_IN_C <= 1'b0;
    chk("captures", 32'h1, caps[3] - base);
    $display("capture done");
  endtask : t_cap

  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    t_regs();
    t_pwm();
    t_lock();
    t_fast();
    t_cap();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    final_report();
  end
endmodule : tb_timer_channel_mode_control
